/* File: hw/audio_extract_pkg.sv */
package audio_extract_pkg;
    // buffer address width
    localparam int ADR_W = 9;
    localparam int EXT_ADR_W = ADR_W + 1;
    localparam int FIFO_DEPTH = 8;
    localparam logic [9:0] DEL_DID = 10'h180;
    localparam logic [4:0] DID_AUD_HI = 5'h1f;
    localparam logic [5:0] DID_CTRL_HI = 6'h3b;
    localparam logic [3:0] ADF_GAP = 4'h3;
    localparam logic [1:0] PH_LAST = 2'h2;
    localparam logic [7:0] EXT_STEP = 8'h02;

    typedef enum {PK_NONE, PK_DATA, PK_EXT, PK_CTRL} pkt_kind_t;
    typedef enum {S_IDLE, S_DID, S_DBN, S_DC, S_UDW, S_CS} in_state_t;
    typedef enum {O_WAIT1, O_READ1, O_CHECK, O_OUT1, O_WAIT2, O_READ2, O_OUT2} out_state_t;

    // audio memory word
    typedef struct packed {
        logic [6:0] spare;
        logic [3:0] vucp;
        logic z;
        logic [1:0] grp;
        logic [1:0] chan;
        logic [19:0] aud;
    } aud_word_t;

    // extended memory word
    typedef struct packed {
        logic [8:0] spare;
        logic valid;
        logic [7:0] data;
    } ext_word_t;

    // sample as handed to the consumer
    typedef struct packed {
        logic ext_valid;
        logic [7:0] ext;
        logic [3:0] vucp;
        logic z;
        logic [1:0] grp;
        logic [1:0] chan;
        logic [19:0] aud;
    } sample_t;

    // packet kind of a did byte
    function automatic pkt_kind_t did_kind(input logic [7:0] did);
        if (did[7:3] == DID_AUD_HI) begin
            did_kind = did[0] ? PK_DATA : PK_EXT;
        end else if (did[7:2] == DID_CTRL_HI) begin
            did_kind = PK_CTRL;
        end else begin
            did_kind = PK_NONE;
        end
    endfunction

    // audio group of a did byte
    function automatic logic [1:0] did_group(input logic [7:0] did);
        if (did[7:3] == DID_AUD_HI) begin
            did_group = ~did[2:1];
        end else begin
            did_group = ~did[1:0];
        end
    endfunction
endpackage

/* File: hw/sample_store_default.sv */
`timescale 1ns/10ps
module sample_store_default
    import audio_extract_pkg::*;
(
    input wire logic clk, // core clock
    input wire logic aud_we, // audio word write
    input wire logic [ADR_W-1:0] aud_adr, // audio write index
    input wire aud_word_t aud_wd, // audio write word
    input wire logic ext_we, // extended word write
    input wire logic [EXT_ADR_W-1:0] ext_adr, // extended write index
    input wire ext_word_t ext_wd, // extended write word
    input wire logic [ADR_W-1:0] rd_adr, // read index
    output aud_word_t rd_aud, // audio word at read index
    output ext_word_t rd_ext // extended word at read index
);
    // 512x36 audio store and 1024x18 extended store, low half in use
    aud_word_t aud_mem [2**ADR_W];
    ext_word_t ext_mem [2**EXT_ADR_W];

    // audio memory write
    always_ff @(posedge clk) begin
        if (aud_we) begin
            aud_mem[aud_adr] <= aud_wd;
        end
    end

    // extended memory write
    always_ff @(posedge clk) begin
        if (ext_we) begin
            ext_mem[ext_adr] <= ext_wd;
        end
    end

    assign rd_aud = aud_mem[rd_adr];
    assign rd_ext = ext_mem[{1'b0, rd_adr}];
endmodule

/* File: hw/sample_fifo.sv */
`timescale 1ns/10ps
module sample_fifo #(
    parameter int WIDTH = 8, // word width
    parameter int DEPTH = 8 // word count, power of two
) (
    input wire logic clk, // core clock
    input wire logic rst, // async reset, high
    input wire logic clr, // sync flush
    input wire logic in_valid, // write request
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // write word
    output logic out_valid, // word available
    input wire logic out_ready, // reader takes word
    output logic [WIDTH-1:0] out_data // head word
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wp_r;
    logic [AW:0] rp_r;
    logic push;
    logic pop;

    // full when pointers differ only in the wrap bit
    assign in_ready = (wp_r ^ rp_r) != {1'b1, {AW{1'b0}}};
    assign out_valid = wp_r != rp_r;
    assign out_data = mem[rp_r[AW-1:0]];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // pointers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wp_r <= '0;
            rp_r <= '0;
        end else if (clr) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_r + (AW+1)'(push);
            rp_r <= rp_r + (AW+1)'(pop);
        end
    end

    // storage
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end
endmodule

/* File: hw/audio_extract_core.sv */
`timescale 1ns/10ps
// Overview of operation
// [R1] four-bit deletion mask, bit 0 is group 1
// [R2] masked group loses data, control, extended packets
// [R3] deletion mask separate from pair extraction mask
// [R4] one video word per clock-enabled cycle
// [R5] video output lags input one enabled cycle
// [R6] deleted packet did becomes 180 hex
// [R7] deleted packet gets a correct checksum
// [R8] downstream must recompute edh after deletion
// [R9] strict: extended packet must follow immediately
// [R10] relaxed: wait to blanking end, next packet
// [R11] no extended packet: release as 20-bit samples
// [R12] timeout counter width parameter, elapses at all-ones
// [R13] sample buffer holds 512 samples
// [R14] no overflow detection, late samples lost
// [R15] every sample stored, enabled or not
// [R16] two memories: 512x36 audio, 1024x18 extended
// [R17] buffer address width is one constant
// [R18] empty when read pointer equals write pointer
// [R19] write pointer moves only after packets complete
// [R20] read each sample, output if pair enabled
// [R21] eight-bit pair mask gates sample output
// [R22] offer held until consumer signals taken
// [R23] new checksum starts from new did value
// [R24] sync clear empties buffer, idles machines
module audio_extract_core
    import audio_extract_pkg::*;
#(
    parameter logic STRICT_EXTENSION_POLICY = 1'b1, // extension policy
    parameter int STREAM_TIMEOUT_WIDTH = 10 // timeout width
) (
    input wire logic I_MCLK, // core clock
    input wire logic I_SYS_RST, // async reset, high
    input wire logic I_CLR, // sync clear
    input wire logic I_IN_CE, // input word enable
    input wire logic [9:0] I_VID_DATA, // video word in
    input wire logic I_ADF, // flag end
    input wire logic I_SAV, // start of active video
    input wire logic [3:0] I_DEL_GROUPS, // group deletion mask
    input wire logic [7:0] I_CHPAIR_EN, // channel pair output mask
    input wire logic I_SAMPLE_TAKEN, // consumer ack
    output logic [9:0] O_VIDEO, // modified video out
    output logic O_SAMPLE_OFFER, // sample offered
    output sample_t O_SAMPLE // offered sample
);
    in_state_t in_st_r;
    pkt_kind_t kind_r;
    pkt_kind_t kind_now;
    logic [1:0] grp_r;
    logic [1:0] grp_now;
    logic del_r;
    logic [8:0] csum_r;
    logic [7:0] dc_r;
    logic [7:0] cnt_r;
    logic [1:0] ph_r;
    logic [17:0] acc_r;
    logic [ADR_W-1:0] wr_adr_r;
    logic [ADR_W-1:0] base_r;
    logic [ADR_W-1:0] wr_ptr_r;
    logic [ADR_W-1:0] pend_end_r;
    logic [ADR_W-1:0] ext_adr_r;
    logic [1:0] pend_grp_r;
    logic pend_r;
    logic ext_on_r;
    logic [3:0] gap_r;
    logic [STREAM_TIMEOUT_WIDTH-1:0] tmo_r;
    logic abort;
    logic commit;
    logic last_udw;
    logic aud_we;
    logic ext_we;
    aud_word_t aud_wd;
    ext_word_t ext_wd;
    logic [9:0] vmod;
    out_state_t out_st_r;
    logic [ADR_W-1:0] rd_ptr_r;
    logic empty;
    aud_word_t rd_aud;
    ext_word_t rd_ext;
    sample_t hold_r;
    logic push;
    logic push_ready;
    logic fifo_valid;
    logic fifo_take;
    sample_t fifo_data;

    // did decode
    assign kind_now = did_kind(I_VID_DATA[7:0]);
    assign grp_now = did_group(I_VID_DATA[7:0]);
    assign last_udw = (cnt_r == dc_r - 8'h01);
    // flag or sav cuts off a packet
    assign abort = I_IN_CE & (I_ADF | I_SAV) & (in_st_r != S_IDLE);

    // pending samples release conditions
    always_comb begin
        commit = 1'b0;
        if (I_IN_CE & pend_r) begin
            if (I_SAV) begin
                commit = 1'b1; // see R10
            end else if (in_st_r == S_DID & ~I_ADF) begin
                commit = ~(kind_now == PK_EXT & grp_now == pend_grp_r); // see R10
            end else if (in_st_r == S_CS & kind_r == PK_EXT & ext_on_r) begin
                commit = 1'b1; // see R19
            end else if (in_st_r == S_IDLE & ~I_ADF & STRICT_EXTENSION_POLICY
                         & gap_r == ADF_GAP) begin
                commit = 1'b1; // see R9 see R11
            end else if (&tmo_r) begin
                commit = 1'b1; // see R12
            end
        end
        if (I_IN_CE & I_ADF & in_st_r == S_UDW & kind_r == PK_EXT & ext_on_r) begin
            commit = 1'b1; // see R11
        end
    end

    // input packet state machine
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            in_st_r <= S_IDLE;
            kind_r <= PK_NONE;
            grp_r <= 2'h0;
            dc_r <= 8'h00;
            cnt_r <= 8'h00;
            ph_r <= 2'h0;
            acc_r <= 18'h00000;
        end else if (I_CLR) begin
            in_st_r <= S_IDLE; // see R24
            kind_r <= PK_NONE;
        end else if (I_IN_CE) begin
            if (I_SAV) begin
                in_st_r <= S_IDLE;
            end else if (I_ADF) begin
                in_st_r <= S_DID;
            end else begin
                case (in_st_r)
                    S_IDLE: in_st_r <= S_IDLE;
                    S_DID: begin
                        kind_r <= kind_now;
                        grp_r <= grp_now;
                        in_st_r <= (kind_now == PK_NONE) ? S_IDLE : S_DBN;
                    end
                    S_DBN: in_st_r <= S_DC;
                    S_DC: begin
                        dc_r <= I_VID_DATA[7:0];
                        cnt_r <= 8'h00;
                        ph_r <= 2'h0;
                        in_st_r <= (I_VID_DATA[7:0] == 8'h00) ? S_CS : S_UDW;
                    end
                    S_UDW: begin
                        cnt_r <= cnt_r + 8'h01;
                        ph_r <= (ph_r == PH_LAST) ? 2'h0 : ph_r + 2'h1;
                        if (ph_r == 2'h0) begin
                            acc_r[8:0] <= I_VID_DATA[8:0];
                        end
                        if (ph_r == 2'h1) begin
                            acc_r[17:9] <= I_VID_DATA[8:0];
                        end
                        if (last_udw) begin
                            in_st_r <= S_CS;
                        end
                    end
                    S_CS: in_st_r <= S_IDLE;
                    default: in_st_r <= S_IDLE;
                endcase
            end
        end
    end

    // memory write strobes and words
    assign aud_we = I_IN_CE & ~I_ADF & ~I_SAV & in_st_r == S_UDW & kind_r == PK_DATA
                    & ph_r == PH_LAST; // see R15
    assign ext_we = aud_we | (I_IN_CE & ~I_ADF & ~I_SAV & in_st_r == S_UDW
                    & kind_r == PK_EXT & ext_on_r);
    always_comb begin
        aud_wd = '0;
        aud_wd.aud = {I_VID_DATA[4:0], acc_r[17:9], acc_r[8:3]};
        aud_wd.chan = acc_r[2:1];
        aud_wd.z = acc_r[0];
        aud_wd.vucp = I_VID_DATA[8:5];
        aud_wd.grp = grp_r;
        ext_wd = '0;
        ext_wd.valid = ~aud_we; // low with audio word, high on extension
        ext_wd.data = I_VID_DATA[7:0];
    end

    // write address, pending flag and write pointer
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            wr_adr_r <= '0;
            base_r <= '0;
            wr_ptr_r <= '0;
            pend_end_r <= '0;
            ext_adr_r <= '0;
            pend_grp_r <= 2'h0;
            pend_r <= 1'b0;
            ext_on_r <= 1'b0;
        end else if (I_CLR) begin
            wr_adr_r <= '0; // see R24
            base_r <= '0;
            wr_ptr_r <= '0;
            pend_r <= 1'b0;
            ext_on_r <= 1'b0;
        end else begin
            if (commit) begin
                wr_ptr_r <= pend_end_r; // see R19
                pend_r <= 1'b0;
                ext_on_r <= 1'b0;
            end
            if (abort & kind_r == PK_DATA & in_st_r != S_DID) begin
                wr_adr_r <= base_r; // drop aborted samples
            end else if (aud_we) begin
                wr_adr_r <= wr_adr_r + 1'b1; // see R14
            end
            if (I_IN_CE & ~I_ADF & ~I_SAV) begin
                if (in_st_r == S_DID & kind_now == PK_DATA) begin
                    base_r <= wr_adr_r;
                end
                if (in_st_r == S_DID & kind_now == PK_EXT & pend_r
                    & grp_now == pend_grp_r) begin
                    ext_on_r <= 1'b1; // see R10
                    ext_adr_r <= base_r;
                end
                if (ext_we & kind_r == PK_EXT) begin
                    ext_adr_r <= ext_adr_r + ADR_W'(EXT_STEP);
                end
                if (in_st_r == S_CS & kind_r == PK_DATA) begin
                    pend_r <= 1'b1;
                    pend_end_r <= wr_adr_r;
                    pend_grp_r <= grp_r;
                end
            end
        end
    end

    // gap since any packet end, pending timeout
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            gap_r <= 4'h0;
            tmo_r <= '0;
        end else if (I_IN_CE) begin
            if (in_st_r == S_CS) begin
                gap_r <= 4'h1;
            end else if (gap_r != 4'hf) begin
                gap_r <= gap_r + 4'h1; // see R9
            end
            tmo_r <= (pend_r & ~commit) ? tmo_r + 1'b1 : '0; // see R12
        end
    end

    // did swap and checksum rewrite
    always_comb begin
        vmod = I_VID_DATA;
        if (in_st_r == S_DID & kind_now != PK_NONE & I_DEL_GROUPS[grp_now]) begin
            vmod = DEL_DID; // see R1 see R2 see R3 see R6
        end else if (in_st_r == S_CS & del_r) begin
            vmod = {~csum_r[8], csum_r}; // see R7
        end
    end

    // checksum of the packet being deleted
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            del_r <= 1'b0;
            csum_r <= 9'h000;
        end else if (I_IN_CE) begin
            if (in_st_r == S_DID) begin
                del_r <= vmod == DEL_DID & ~I_ADF;
                csum_r <= DEL_DID[8:0]; // see R23
            end else if (in_st_r == S_CS | I_ADF | I_SAV) begin
                del_r <= 1'b0;
            end else begin
                csum_r <= csum_r + I_VID_DATA[8:0]; // see R23
            end
        end
    end

    // video out, one enabled cycle late
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_VIDEO <= 10'h000;
        end else if (I_IN_CE) begin
            O_VIDEO <= vmod; // see R4 see R5
        end
    end

    // circular sample buffer
    sample_store_default u_store (
        .clk(I_MCLK),
        .aud_we(aud_we),
        .aud_adr(wr_adr_r),
        .aud_wd(aud_wd),
        .ext_we(ext_we),
        .ext_adr({1'b0, (kind_r == PK_EXT) ? ext_adr_r : wr_adr_r}), // see R16
        .ext_wd(ext_wd),
        .rd_adr(rd_ptr_r),
        .rd_aud(rd_aud),
        .rd_ext(rd_ext)
    ); // see R13 see R17

    assign empty = rd_ptr_r == wr_ptr_r; // see R18
    assign push = (out_st_r == O_OUT1 | out_st_r == O_OUT2);

    // output state machine, samples read in pairs
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            out_st_r <= O_WAIT1;
            rd_ptr_r <= '0;
            hold_r <= '0;
        end else if (I_CLR) begin
            out_st_r <= O_WAIT1; // see R24
            rd_ptr_r <= '0;
        end else begin
            case (out_st_r)
                O_WAIT1: out_st_r <= empty ? O_WAIT1 : O_READ1;
                O_READ1: begin
                    rd_ptr_r <= rd_ptr_r + 1'b1;
                    hold_r <= {rd_ext.valid, rd_ext.data, rd_aud.vucp, rd_aud.z,
                               rd_aud.grp, rd_aud.chan, rd_aud.aud};
                    out_st_r <= rd_aud.chan[0] ? O_WAIT1 : O_CHECK;
                end
                O_CHECK: begin
                    out_st_r <= I_CHPAIR_EN[{hold_r.grp, hold_r.chan[1]}] ? O_OUT1
                                : O_WAIT1; // see R20 see R21
                end
                O_OUT1: out_st_r <= push_ready ? O_WAIT2 : O_OUT1;
                O_WAIT2: out_st_r <= empty ? O_WAIT2 : O_READ2;
                O_READ2: begin
                    rd_ptr_r <= rd_ptr_r + 1'b1;
                    hold_r.aud <= rd_aud.aud;
                    hold_r.chan <= rd_aud.chan;
                    hold_r.z <= rd_aud.z;
                    hold_r.vucp <= rd_aud.vucp;
                    out_st_r <= O_OUT2;
                end
                O_OUT2: out_st_r <= push_ready ? O_WAIT1 : O_OUT2;
                default: out_st_r <= O_WAIT1;
            endcase
        end
    end

    // queue ahead of the consumer handshake
    sample_fifo #(
        .WIDTH($bits(sample_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(I_MCLK),
        .rst(I_SYS_RST),
        .clr(I_CLR),
        .in_valid(push),
        .in_ready(push_ready),
        .in_data(hold_r),
        .out_valid(fifo_valid),
        .out_ready(fifo_take),
        .out_data(fifo_data)
    );

    assign fifo_take = ~O_SAMPLE_OFFER | I_SAMPLE_TAKEN;

    // offer register, held until taken
    always_ff @(posedge I_MCLK or posedge I_SYS_RST) begin
        if (I_SYS_RST) begin
            O_SAMPLE_OFFER <= 1'b0;
            O_SAMPLE <= '0;
        end else if (I_CLR) begin
            O_SAMPLE_OFFER <= 1'b0;
        end else if (fifo_take) begin
            O_SAMPLE_OFFER <= fifo_valid; // see R22
            O_SAMPLE <= fifo_data;
        end
    end
endmodule

/* File: tb/audio_extract_core_asserts.sv */
`timescale 1ns/10ps
module audio_extract_core_asserts
    import audio_extract_pkg::*;
(
    input wire logic I_MCLK, // core clock
    input wire logic I_SYS_RST, // async reset
    input wire logic I_CLR, // sync clear
    input wire logic I_IN_CE, // word enable
    input wire logic [9:0] I_VID_DATA, // video in
    input wire logic I_ADF, // flag end
    input wire logic [3:0] I_DEL_GROUPS, // deletion mask
    input wire logic [7:0] I_CHPAIR_EN, // pair mask
    input wire logic I_SAMPLE_TAKEN, // consumer ack
    input wire logic [9:0] O_VIDEO, // video out
    input wire logic O_SAMPLE_OFFER, // sample offered
    input wire sample_t O_SAMPLE // offered sample
);
    logic is_aud;
    logic [1:0] grp_of;
    logic offer;
    // audio group named by a did word
    assign is_aud = (I_VID_DATA[7:3] == 5'h1f) || (I_VID_DATA[7:2] == 6'h3b);
    assign grp_of = (I_VID_DATA[7:3] == 5'h1f) ? ~I_VID_DATA[2:1] : ~I_VID_DATA[1:0];
    assign offer = O_SAMPLE_OFFER;
    default clocking cb @(posedge I_MCLK);
    endclocking
    default disable iff (I_SYS_RST);
    sequence s_did;
        (I_IN_CE && I_ADF) ##1 (I_IN_CE && is_aud);
    endsequence
    sequence s_first_taken;
        offer && I_SAMPLE_TAKEN && !O_SAMPLE.chan[0];
    endsequence
    a_video_lag: assert property (I_IN_CE && I_DEL_GROUPS == 4'h0
        |=> O_VIDEO == $past(I_VID_DATA)) else $error("video lag wrong");
    a_video_hold: assert property (!I_IN_CE |=> $stable(O_VIDEO))
        else $error("video moved idle");
    a_del_did: assert property (s_did ##0 I_DEL_GROUPS[grp_of]
        |=> O_VIDEO == DEL_DID) else $error("did not deleted");
    a_keep_did: assert property (s_did ##0 !I_DEL_GROUPS[grp_of]
        |=> O_VIDEO == $past(I_VID_DATA)) else $error("did altered");
    a_offer_hold: assert property (offer && !I_SAMPLE_TAKEN && !I_CLR
        |=> offer && $stable(O_SAMPLE)) else $error("offer not held");
    a_offer_fall: assert property ($fell(offer)
        |-> $past(I_SAMPLE_TAKEN) || $past(I_CLR)) else $error("offer fell untaken");
    a_clr_idle: assert property (I_CLR |=> !offer [*3])
        else $error("offer after clear");
    a_pair_second: assert property (s_first_taken
        |=> !offer until (offer && O_SAMPLE.chan[0])) else $error("pair order");
    a_pair_bound: assert property (s_first_taken |-> ##[1:40] offer)
        else $error("pair late");
    a_pair_enabled: assert property (offer
        |-> I_CHPAIR_EN[{O_SAMPLE.grp, O_SAMPLE.chan[1]}]) else $error("masked pair offered");
endmodule
bind audio_extract_core audio_extract_core_asserts chk_u (
    .I_MCLK(I_MCLK), .I_SYS_RST(I_SYS_RST), .I_CLR(I_CLR), .I_IN_CE(I_IN_CE),
    .I_VID_DATA(I_VID_DATA), .I_ADF(I_ADF), .I_DEL_GROUPS(I_DEL_GROUPS),
    .I_CHPAIR_EN(I_CHPAIR_EN), .I_SAMPLE_TAKEN(I_SAMPLE_TAKEN), .O_VIDEO(O_VIDEO),
    .O_SAMPLE_OFFER(O_SAMPLE_OFFER), .O_SAMPLE(O_SAMPLE)
);

/* File: tb/sample_consumer.sv */
`timescale 1ns/10ps
module sample_consumer
    import audio_extract_pkg::*;
(
    input wire logic i_clk, // core clock
    input wire logic i_rst, // async reset, high
    input wire logic i_offer, // sample offered
    input wire sample_t i_sample, // offered sample
    input wire logic [3:0] i_delay, // wait before taking
    output logic o_taken // sample taken
);
    logic [3:0] wait_r;
    sample_t seen[$];
    // take each offer after the set wait
    always @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wait_r <= 4'h0;
            o_taken <= 1'b0;
        end else if (o_taken) begin
            o_taken <= 1'b0;
            wait_r <= 4'h0;
            seen.push_back(i_sample);
        end else if (i_offer && wait_r >= i_delay) begin
            o_taken <= 1'b1;
        end else if (i_offer) begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule

/* File: tb/audio_extract_core_bench.sv */
`timescale 1ns/10ps
module audio_extract_core_bench
    import audio_extract_pkg::*;
;
    localparam int SW = $bits(sample_t);
    typedef struct packed {
        logic [3:0] del;
        logic [7:0] en;
        logic [1:0] grp;
        logic pr;
        logic gone;
        logic out;
    } row_t;
    logic mclk, rst, clr, ce, adf, sav, taken, offer, pend_ce;
    logic [9:0] vid, video, shown, pend_e;
    logic [3:0] del, dly;
    logic [7:0] en;
    sample_t smp;
    logic [9:0] udw[$];
    sample_t exp_s[$];
    int fail_count = 0;
    int num_checks = 0;
    // deletion mask, pair mask, group, pair, deleted, offered
    row_t rows[6] = '{'{4'h1, 8'hff, 2'd0, 1'b0, 1'b1, 1'b1},
        '{4'h2, 8'h04, 2'd1, 1'b0, 1'b1, 1'b1}, '{4'h4, 8'hdf, 2'd2, 1'b1, 1'b1, 1'b0},
        '{4'h8, 8'h80, 2'd3, 1'b1, 1'b1, 1'b1}, '{4'he, 8'hff, 2'd0, 1'b1, 1'b0, 1'b1},
        '{4'h0, 8'h00, 2'd1, 1'b1, 1'b0, 1'b0}};
    audio_extract_core #(.STREAM_TIMEOUT_WIDTH(4)) dut_u (
        .I_MCLK(mclk), .I_SYS_RST(rst), .I_CLR(clr), .I_IN_CE(ce), .I_VID_DATA(vid),
        .I_ADF(adf), .I_SAV(sav), .I_DEL_GROUPS(del), .I_CHPAIR_EN(en),
        .I_SAMPLE_TAKEN(taken), .O_VIDEO(video), .O_SAMPLE_OFFER(offer), .O_SAMPLE(smp));
    sample_consumer cons_u (.i_clk(mclk), .i_rst(rst), .i_offer(offer), .i_sample(smp),
        .i_delay(dly), .o_taken(taken));
    // free-running core clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic check(input logic [SW-1:0] seen, exp, input string what);
        num_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    function automatic logic [9:0] w10(input logic [7:0] b);
        return {~^b, ^b, b};
    endfunction
    function automatic logic [9:0] u10(input logic [8:0] v);
        return {~v[8], v};
    endfunction
    // one input word, checks the previous enabled word
    task automatic put(input logic [9:0] w, input logic a, c, input logic [9:0] e);
        @(posedge mclk);
        vid <= w;
        adf <= a;
        ce <= c;
        if (pend_ce) shown = pend_e;
        #1 check(SW'(video), SW'(shown), "video");
        pend_ce = c;
        pend_e = e;
    endtask
    task automatic idle(input int n, input logic c);
        repeat (n) put(10'h040, 1'b0, c, 10'h040);
    endtask
    // one sample into the body, plus its expectation
    task automatic add(input logic [1:0] g, ch, input logic [8:0] e, input logic keep);
        logic [19:0] a;
        a = {16'hab00, g, ch};
        udw.push_back(u10({a[5:0], ch, 1'b0}));
        udw.push_back(u10(a[14:6]));
        udw.push_back(u10({4'h0, a[19:15]}));
        if (keep) exp_s.push_back({e, 4'h0, 1'b0, g, ch, a});
    endtask
    // flag, did, count words, body, checksum
    task automatic anc(input logic [7:0] d, input logic gone);
        logic [8:0] s;
        logic [9:0] w;
        s = 9'h180;
        udw.push_front(w10(8'(udw.size())));
        udw.push_front(w10(8'h01));
        put(10'h000, 1'b0, 1'b1, 10'h000);
        put(10'h3ff, 1'b0, 1'b1, 10'h3ff);
        put(10'h3ff, 1'b1, 1'b1, 10'h3ff);
        put(w10(d), 1'b0, 1'b1, gone ? DEL_DID : w10(d));
        while (udw.size() > 0) begin
            w = udw.pop_front();
            s = s + w[8:0];
            put(w, 1'b0, 1'b1, w);
        end
        put(10'h2aa, 1'b0, 1'b1, gone ? {~s[8], s} : 10'h2aa);
    endtask
    // wait for samples, compare in order
    task automatic drain(input string name);
        sample_t got;
        int n = 0;
        while (cons_u.seen.size() < exp_s.size()) begin
            @(posedge mclk);
            n++;
            if (n > 500) begin
                fail_count++;
                wrap_up();
            end
        end
        repeat (40) @(posedge mclk);
        check(SW'(cons_u.seen.size()), SW'(exp_s.size()), "sample count");
        while (exp_s.size() > 0 && cons_u.seen.size() > 0) begin
            got = cons_u.seen.pop_front();
            if (!got.ext_valid) got.ext = 8'h00;
            check(got, exp_s.pop_front(), "sample");
        end
        exp_s.delete();
        cons_u.seen.delete();
        $display("test %s done", name);
    endtask
    initial begin
        int n;
        {rst, clr, ce, adf, sav, vid, del, en, dly, pend_ce, shown} = '0;
        rst = 1'b1;
        repeat (3) @(posedge mclk);
        rst <= 1'b0;
        foreach (rows[i]) begin
            del <= rows[i].del;
            en <= rows[i].en;
            add(rows[i].grp, {rows[i].pr, 1'b0}, 9'h0, rows[i].out);
            add(rows[i].grp, {rows[i].pr, 1'b1}, 9'h0, rows[i].out);
            anc(8'hff - {5'h0, rows[i].grp, 1'b0}, rows[i].gone);
            idle(4, 1'b1);
            drain("row");
        end
        // data, extended, control packets, slow consumer
        dly <= 4'h6;
        del <= 4'h1;
        en <= 8'h01;
        add(2'd0, 2'b00, 9'h15a, 1'b1);
        add(2'd0, 2'b01, 9'h15a, 1'b1);
        anc(8'hff, 1'b1);
        udw.push_back(w10(8'h5a));
        anc(8'hfe, 1'b1);
        udw.push_back(w10(8'h11));
        udw.push_back(w10(8'h22));
        anc(8'hef, 1'b1);
        idle(2, 1'b0);
        idle(4, 1'b1);
        drain("extended");
        // clear while a sample is offered
        dly <= 4'hf;
        del <= 4'h0;
        en <= 8'hff;
        add(2'd1, 2'b10, 9'h0, 1'b0);
        add(2'd1, 2'b11, 9'h0, 1'b0);
        anc(8'hfd, 1'b0);
        idle(4, 1'b1);
        n = 0;
        while (offer !== 1'b1 && n < 100) begin
            @(posedge mclk);
            n++;
        end
        check(SW'(offer), SW'(1), "offer before clear");
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        #1 check(SW'(offer), SW'(0), "offer after clear");
        drain("clear");
        // mid-run reset, prompt consumer
        @(posedge mclk);
        rst <= 1'b1;
        ce <= 1'b0;
        dly <= 4'h0;
        @(posedge mclk);
        #1 check(SW'({offer, video}), SW'(0), "outputs in reset");
        rst <= 1'b0;
        pend_ce = 1'b0;
        shown = 10'h000;
        add(2'd3, 2'b10, 9'h0, 1'b1);
        add(2'd3, 2'b11, 9'h0, 1'b1);
        anc(8'hf9, 1'b0);
        idle(1, 1'b1);
        sav <= 1'b1; // blanking end releases the samples
        idle(1, 1'b1);
        sav <= 1'b0;
        idle(3, 1'b1);
        drain("reset");
        wrap_up();
    end
endmodule
